// ==== rtl/acf_formatter.sv ====
// Output code formatter of a 10-bit flash converter, with output FIFO.
// Assumes encode and format straps arrive from pins (asynchronous) and
// the quantised step arrives on i_ref_clk from the comparator bank.
//
// How it works
// - Two flip straps choose the output coding
// - Offset binary, two's complement, and inverses
// - Over-range flag set above top reference
// - Over-range forces the data bits to the full code as flipped by the straps
// - Flag high on any step of 1024 or more
// - Sample after fixed delay past encode rise
`timescale 1ns/1ps
module acf_formatter
  import acf_pkg::*;
#(
  parameter int DEPTH = ACF_FIFO_DEPTH,
  parameter int APERTURE_CYC = ACF_APERTURE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_encode,
  input wire logic i_top_bit_flip,
  input wire logic i_low_bits_flip,
  input wire logic [ACF_STEP_W-1:0] i_conv_step,
  input wire logic i_sample_ready,
  output logic o_sample_valid,
  output logic [ACF_CODE_W-1:0] o_sample_code,
  output logic o_over_range,
  output logic o_sample_lost,
  output logic o_fifo_full
);
  initial begin
    if (APERTURE_CYC < 1 || APERTURE_CYC >= (1 << ACF_CNT_W)) begin
      $error("acf_formatter: APERTURE_CYC out of range");
    end
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("acf_formatter: DEPTH must be a power of two");
    end
    if (ACF_WORD_W != ACF_CODE_W + 1) begin
      $error("acf_formatter: word must hold code and flag");
    end
  end

  function automatic logic [ACF_CODE_W-1:0] fmt_code(
    input logic [ACF_STEP_W-1:0] step,
    input logic top_flip,
    input logic low_flip
  );
    logic [ACF_CODE_W-1:0] base;
    // Above full scale the data stays at the top code
    base = step[ACF_OVR_BIT] ? ACF_FULL_CODE : step[ACF_CODE_W-1:0];
    base[ACF_TOP_BIT] = base[ACF_TOP_BIT] ^ top_flip;
    base[ACF_TOP_BIT-1:0] = base[ACF_TOP_BIT-1:0] ^ {9{low_flip}};
    return base;
  endfunction : fmt_code

  // Three-stage synchronisers; a change counts when stages two and three agree
  localparam int PIN_N = 3;
  localparam int PIN_ENC = 0;
  localparam int PIN_TOP = 1;
  localparam int PIN_LOW = 2;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_lvl_next;
  logic enc_rise;
  logic top_lvl;
  logic low_lvl;

  assign pin_raw[PIN_ENC] = i_encode;
  assign pin_raw[PIN_TOP] = i_top_bit_flip;
  assign pin_raw[PIN_LOW] = i_low_bits_flip;

  for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic lvl_q;
    logic lvl_d;

    always_comb begin
      sync_d = {sync_q[1:0], pin_raw[g]};
      lvl_d = lvl_q;
      // Stage one may still be settling, so only two and three decide
      if (sync_q[1] == sync_q[2]) begin
        lvl_d = sync_q[2];
      end
    end

    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        sync_q <= ACF_SYNC_RST;
        lvl_q <= 1'b0;
      end else begin
        sync_q <= sync_d;
        lvl_q <= lvl_d;
      end
    end

    assign pin_lvl[g] = lvl_q;
    assign pin_lvl_next[g] = lvl_d;
  end : g_pin_sync

  assign enc_rise = pin_lvl_next[PIN_ENC] && !pin_lvl[PIN_ENC];

  // Straps are static in use; resync only guards against slow ramps
  assign top_lvl = pin_lvl[PIN_TOP];
  assign low_lvl = pin_lvl[PIN_LOW];

  // Sampling sequencer: state and aperture counter
  acf_state_t state_q, state_d;
  logic [ACF_CNT_W-1:0] cnt_q, cnt_d;
  logic sample_now;

  acf_word_if #(.W(ACF_WORD_W)) wr_if ();

  assign wr_if.valid = (state_q == ACF_PUSH);
  assign sample_now = (state_q == ACF_WAIT) && (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ACF_IDLE: begin
        if (enc_rise) begin
          cnt_d = ACF_CNT_W'(APERTURE_CYC - 1);
          state_d = ACF_WAIT;
        end
      end
      ACF_WAIT: begin
        if (cnt_q == '0) begin
          state_d = ACF_PUSH;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ACF_PUSH: begin
        // A full FIFO stalls here until the reader makes room
        if (wr_if.ready) begin
          state_d = ACF_IDLE;
        end
      end
      default: begin
        state_d = ACF_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_q <= ACF_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Coded word: code and flag are fixed together at the sampling instant
  logic [ACF_WORD_W-1:0] word_q, word_d;

  assign wr_if.data = word_q;

  always_comb begin
    word_d = word_q;
    if (sample_now) begin
      word_d = {i_conv_step[ACF_OVR_BIT],
                fmt_code(i_conv_step, top_lvl, low_lvl)};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  // Lost pulse: a rise while a word is still owed cannot be served
  logic lost_q, lost_d;

  always_comb begin
    lost_d = 1'b0;
    if (enc_rise) begin
      if (state_q == ACF_WAIT) begin
        lost_d = 1'b1;
      end
      if (state_q == ACF_PUSH && !wr_if.ready) begin
        lost_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= lost_d;
    end
  end

  assign o_sample_lost = lost_q;

  logic [ACF_WORD_W-1:0] rd_word;

  acf_fifo #(
    .WIDTH(ACF_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .wr(wr_if),
    .o_valid(o_sample_valid),
    .i_ready(i_sample_ready),
    .o_data(rd_word),
    .o_full(o_fifo_full)
  );

  assign o_sample_code = rd_word[ACF_CODE_W-1:0];
  assign o_over_range = rd_word[ACF_OVR_BIT];
endmodule : acf_formatter

// ==== pkg/acf_pkg.sv ====
// Constants and types shared by the output code formatter and its FIFO.
// Assumes a single 40 MHz clock; all counts are derived from that rate.
package acf_pkg;
  localparam int ACF_CODE_W = 10;
  localparam int ACF_STEP_W = 11;
  localparam int ACF_WORD_W = 11;
  localparam int ACF_FIFO_DEPTH = 8;
  localparam int ACF_CLK_PERIOD_PS = 25000;
  // Delay between encode edge and sampling instant, in picoseconds
  localparam int ACF_APERTURE_PS = 50000;
  // Least time, so rounded up; never below one cycle
  localparam int ACF_APERTURE_CYC_RAW =
    (ACF_APERTURE_PS + ACF_CLK_PERIOD_PS - 1) / ACF_CLK_PERIOD_PS;
  localparam int ACF_APERTURE_CYC =
    (ACF_APERTURE_CYC_RAW < 1) ? 1 : ACF_APERTURE_CYC_RAW;
  localparam int ACF_CNT_W = 4;
  localparam int ACF_TOP_BIT = 9;
  localparam int ACF_OVR_BIT = 10;
  localparam logic [9:0] ACF_FULL_CODE = 10'h3ff;
  localparam logic [9:0] ACF_CODE_RST = 10'h000;
  localparam logic [2:0] ACF_SYNC_RST = 3'h0;
  typedef enum logic [2:0] {
    ACF_IDLE = 3'b001,
    ACF_WAIT = 3'b010,
    ACF_PUSH = 3'b100
  } acf_state_t;
endpackage : acf_pkg

// ==== pkg/acf_word_if.sv ====
// Valid/ready carrier for formatted words between formatter and FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface acf_word_if #(parameter int W = 11);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : acf_word_if

// ==== rtl/acf_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous active-high reset; depth must be a power of two.
`timescale 1ns/1ps
module acf_fifo
  import acf_pkg::*;
#(
  parameter int WIDTH = ACF_WORD_W,
  parameter int DEPTH = ACF_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  acf_word_if.snk wr,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_full
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH != wr.W) begin
      $error("acf_fifo: bad DEPTH or WIDTH");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic empty, push, pop;

  assign empty = (wptr_q == rptr_q);
  assign o_full = (wptr_q[AW] != rptr_q[AW]) &&
                  (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  // Full stalls the writer, so back-pressure reaches the formatter
  assign wr.ready = !o_full;
  assign push = wr.valid && !o_full;
  assign o_valid = !empty;
  assign pop = !empty && i_ready;
  assign o_data = mem_q[rptr_q[AW-1:0]];

  always_comb begin
    wptr_d = wptr_q + (AW+1)'(push);
    rptr_d = rptr_q + (AW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
  end
endmodule : acf_fifo

// ==== bench/acf_formatter_properties.sv ====
// Port checks on the formatter, bound into every instance.
// Assumes straps stay still while words wait in the FIFO.
`timescale 1ns/1ps
module acf_formatter_properties
  import acf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_encode,
  input wire logic i_top_bit_flip,
  input wire logic i_low_bits_flip,
  input wire logic i_sample_ready,
  input wire logic o_sample_valid,
  input wire logic [ACF_CODE_W-1:0] o_sample_code,
  input wire logic o_over_range,
  input wire logic o_sample_lost,
  input wire logic o_fifo_full
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence quiet;
    !o_sample_valid && !o_fifo_full && !o_sample_lost;
  endsequence
  sequence held;
    o_sample_valid && $stable(o_sample_code) && $stable(o_over_range);
  endsequence
  a_start_quiet: assert property ($fell(i_sys_rst) |-> quiet [*4])
    else $error("output active too soon after reset");
  a_over_code: assert property (o_sample_valid && o_over_range |->
    o_sample_code == {~i_top_bit_flip, {9{~i_low_bits_flip}}})
    else $error("over-range word has wrong code");
  a_head_hold: assert property (
    o_sample_valid && !i_sample_ready |=> held)
    else $error("head word moved without a pop");
  a_full_valid: assert property (o_fifo_full |-> o_sample_valid)
    else $error("full without valid");
  a_lost_pulse: assert property (o_sample_lost |=> !o_sample_lost)
    else $error("lost flag too long");
  a_lost_cause: assert property (o_sample_lost |-> $past(i_encode, 2))
    else $error("lost flag without encode");
  a_sample_delay: assert property ($rose(o_sample_valid) |->
    $past(i_encode, 4) && !$past(i_encode, 8))
    else $error("word without timely encode rise");
endmodule : acf_formatter_properties
bind acf_formatter acf_formatter_properties u_props (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_encode(i_encode),
  .i_top_bit_flip(i_top_bit_flip), .i_low_bits_flip(i_low_bits_flip),
  .i_sample_ready(i_sample_ready), .o_sample_valid(o_sample_valid),
  .o_sample_code(o_sample_code), .o_over_range(o_over_range),
  .o_sample_lost(o_sample_lost), .o_fifo_full(o_fifo_full));

// ==== bench/acf_capture_model.sv ====
// Downstream capture model: takes the head word whenever ready.
// Assumes the formatter's clock; ready moves 1 ns after each edge.
`timescale 1ns/1ps
module acf_capture_model (
  input wire logic i_ref_clk,
  input wire logic i_stall,
  output logic o_ready
);
  initial o_ready = 1'b0;
  // Random gaps make words wait, as a slow reader would
  always @(posedge i_ref_clk) begin
    o_ready <= #1 !i_stall && ($urandom_range(0, 1) == 1);
  end
endmodule : acf_capture_model

// ==== bench/acf_formatter_tb.sv ====
// Self-checking bench for the formatter with its capture model.
// Assumes default aperture and depth; expectations queue in order.
`timescale 1ns/1ps
module acf_formatter_tb;
  import acf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enc_pin = 1'b0;
  logic top = 1'b0;
  logic low = 1'b0;
  logic stall = 1'b1;
  logic [ACF_STEP_W-1:0] step = '0;
  logic rdy, vld, ovr, lost, full, v5, v8;
  logic [ACF_CODE_W-1:0] code;
  logic [ACF_WORD_W-1:0] exp_q[$];
  logic [ACF_STEP_W-1:0] pts [5] = '{11'h000, 11'h1ff, 11'h200,
    11'h3ff, 11'h400};
  // Lowest and over-range words per coding, modes 0 to 3
  logic [ACF_CODE_W-1:0] lo_tab [4] = '{10'h000, 10'h1ff, 10'h200, 10'h3ff};
  logic [ACF_WORD_W-1:0] hi_tab [4] = '{11'h7ff, 11'h600, 11'h5ff, 11'h400};
  int error_cnt = 0;
  int comparisons = 0;
  int lost_cnt = 0;
  always #12.5 clk = ~clk;
  acf_formatter DUT (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_encode(enc_pin), .i_top_bit_flip(top), .i_low_bits_flip(low),
    .i_conv_step(step), .i_sample_ready(rdy), .o_sample_valid(vld),
    .o_sample_code(code), .o_over_range(ovr), .o_sample_lost(lost),
    .o_fifo_full(full));
  acf_capture_model u_cap (.i_ref_clk(clk), .i_stall(stall),
    .o_ready(rdy));
  task cmp(input logic [ACF_WORD_W-1:0] e, input logic [ACF_WORD_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task cmp_bit(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_bit
  task complete_run;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // Step is held long past the sampling edge; pin high and low 4 cycles
  task enc_at(input logic [ACF_STEP_W-1:0] s,
    input logic [ACF_WORD_W-1:0] e);
    exp_q.push_back(e);
    step = s;
    enc_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1 enc_pin = 1'b0;
    @(posedge clk);
    #1 v5 = vld;
    repeat (3) @(posedge clk);
    #1 v8 = vld;
  endtask : enc_at
  task enc(input logic [ACF_STEP_W-1:0] s);
    logic [ACF_CODE_W-1:0] b;
    b = s[10] ? ACF_FULL_CODE : s[9:0];
    enc_at(s, {s[10], b ^ {top, {9{low}}}});
  endtask : enc
  task drain;
    while (exp_q.size() != 0) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask : drain
  // Looked at mid-cycle, where valid and ready stand for the next pop
  always @(negedge clk) begin
    if (lost === 1'b1) lost_cnt++;
    if (!rst && vld === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) begin
        comparisons++;
        error_cnt++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 11'bx,
          {ovr, code});
      end
      else cmp(exp_q.pop_front(), {ovr, code});
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    void'($urandom(82));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    stall = 1'b0;
    for (int m = 0; m < 4; m++) begin
      drain();
      {top, low} = 2'(m);
      repeat (6) @(posedge clk);
      #1;
      enc_at(11'h000, {1'b0, lo_tab[m]});
      enc_at(11'h400, hi_tab[m]);
      foreach (pts[i]) enc(pts[i]);
      repeat (4) enc(11'($urandom_range(0, 1024)));
    end
    drain();
    stall = 1'b1;
    enc(11'h200);
    cmp_bit(1'b0, v5);
    cmp_bit(1'b1, v8);
    // Eight fill the FIFO, one stalls in hand, the last is dropped
    repeat (9) enc(11'($urandom_range(0, 1024)));
    void'(exp_q.pop_back());
    cmp_bit(1'b1, full);
    cmp(11'h001, 11'(lost_cnt));
    stall = 1'b0;
    drain();
    cmp_bit(1'b0, vld);
    complete_run();
  end
endmodule : acf_formatter_tb
